/* power_mode_manager.sv */
// Power mode sequencer with wake sources and supply switch controls.
// Functional notes
// - Leave the unpowered state once a battery is present or an RF field is detected.
// - After power-on start in watchful mode ready for RFID or SPI commands.
// - A command or DMA request enters run mode, powering the involved blocks for a limited time.
// - Stand-by never exits by itself, only on RF field or slave select held low long enough.
// - A host write of the wake-up timer configuration word requests stand-by entry.
// - Stand-by is also entered on wake-up timer expiry or on completion of a logging sequence.
// - In sleep only the wake-up timer runs, pulsing an interrupt request each period.
// - Sleep exits on RF field, slave select held low long enough, or a DMA request.
// - In sleep or stand-by the regulated output may optionally be switched off.
// - Digital logic runs on the RC clock; the wake-up timer source is RC or crystal.
// - Device word 03 bit 15 controls the field to battery switch, closed by default.
// - EEPROM word 12 bit 13 selects regulated output on in every powered mode (except the optional sleep/stand-by switch-off) or only in watchful mode.
// - Device word 04 bit 2 bypasses the output regulator.
// - Device word 04 bit 3 selects the high or low voltage range of both regulators.
// - Switch settings come from EEPROM contents and EEPROM-backed latches.
`timescale 1ns/1ps
`include "pwr_regs.svh"
module power_mode_manager
  import pwr_pkg::*;
#(
  parameter int RUN_LIMIT   = `RUN_LIMIT_DEFAULT,
  parameter int WAKE_W      = 16,
  parameter int SS_HOLD_CYC = (`SS_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              battery_present,
  input  wire logic              rf_field,
  input  wire logic              spi_cmd,
  input  wire logic              rfid_cmd,
  input  wire logic              dma_req,
  input  wire logic              run_done,
  input  wire logic              timer_cfg_write,
  input  wire logic              timer_standby_en,
  input  wire logic              log_done,
  input  wire logic              sleep_req,
  input  wire logic              spi_ss_n,
  input  wire logic [WAKE_W-1:0] wake_period,
  input  wire logic              xtal_select,
  input  wire logic              regout_lowpower_off,
  input  wire logic [15:0]       dev_word03,
  input  wire logic [15:0]       dev_word04,
  input  wire logic [15:0]       ee_word12,
  output pwr_pkg::pwr_mode_t     mode_q,
  output logic                   run_power_q,
  output logic                   irq_q,
  output logic                   lf_xtal_en_q,
  output logic                   lf_rc_en_q,
  output logic                   vfield_vbat_closed_q,
  output logic                   regulated_output_en_q,
  output logic                   regulated_output_bypass_q,
  output logic                   hivolt_q,
  output logic                   run_timeout_q
);
  import pwr_pkg::*;

  localparam int RW = $clog2(RUN_LIMIT + 1);

  initial
  begin
    if (RUN_LIMIT < 1)
      $error("RUN_LIMIT must be at least one");
    if (WAKE_W < 2)
      $error("WAKE_W must be at least two");
  end

  pwr_mode_t     mode_d;
  logic [RW-1:0] run_cnt_q;
  logic [RW-1:0] run_cnt_d;
  logic          standby_pend_q;
  logic          standby_pend_d;
  logic          sleep_pend_q;
  logic          sleep_pend_d;
  logic          run_power_d;
  logic          irq_d;
  logic          timeout_d;
  logic          ss_held;
  logic          wake_tick;
  logic          timer_run;
  logic          powered;
  logic          run_req;

  assign powered   = battery_present | rf_field;
  assign run_req   = spi_cmd | rfid_cmd | dma_req;
  // The period counter runs in sleep, and in watchful mode for the armed stand-by countdown.
  assign timer_run = (mode_q == MODE_SLEEP) ||
                     (mode_q == MODE_WATCH && timer_standby_en);

  ss_hold_filter #(
    .HOLD_CYCLES (SS_HOLD_CYC)
  ) u_ss (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .ss_n    (spi_ss_n),
    .held_q  (ss_held)
  );

  wake_timer #(
    .W (WAKE_W)
  ) u_wake (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .run     (timer_run),
    .period  (wake_period),
    .tick_q  (wake_tick)
  );

  always_comb
  begin
    mode_d         = mode_q;
    run_cnt_d      = run_cnt_q;
    standby_pend_d = standby_pend_q | timer_cfg_write | log_done;
    sleep_pend_d   = sleep_pend_q | sleep_req;
    irq_d          = 1'b0;
    timeout_d      = 1'b0;
    unique case (mode_q)
      MODE_OFF:
      begin
        standby_pend_d = 1'b0;
        sleep_pend_d   = 1'b0;
        if (powered)
          mode_d = MODE_WATCH;
      end
      MODE_WATCH:
      begin
        // Only a tick while armed counts as an expired countdown, so a tick after a dropped arm does not.
        if (standby_pend_d || (wake_tick && timer_standby_en))
        begin
          mode_d         = MODE_STANDBY;
          standby_pend_d = 1'b0;
        end
        else if (sleep_pend_d)
        begin
          mode_d       = MODE_SLEEP;
          sleep_pend_d = 1'b0;
        end
        else if (run_req)
        begin
          mode_d    = MODE_RUN;
          run_cnt_d = '0;
        end
      end
      MODE_RUN:
      begin
        run_cnt_d = run_cnt_q + RW'(1);
        // The run time is bounded so a stuck transaction cannot drain the battery.
        if (run_done || run_cnt_q >= RW'(RUN_LIMIT - 1))
        begin
          timeout_d = !run_done;
          if (standby_pend_d)
          begin
            mode_d         = MODE_STANDBY;
            standby_pend_d = 1'b0;
          end
          else if (sleep_pend_d)
          begin
            mode_d       = MODE_SLEEP;
            sleep_pend_d = 1'b0;
          end
          else
            mode_d = MODE_WATCH;
        end
      end
      MODE_STANDBY:
      begin
        standby_pend_d = 1'b0;
        if (rf_field || ss_held)
          mode_d = MODE_WATCH;
      end
      MODE_SLEEP:
      begin
        standby_pend_d = 1'b0;
        irq_d          = wake_tick;
        if (rf_field || ss_held)
          mode_d = MODE_WATCH;
        else if (dma_req)
        begin
          mode_d    = MODE_RUN;
          run_cnt_d = '0;
        end
      end
    endcase
    if (!powered)
      mode_d = MODE_OFF;
    run_power_d = (mode_d == MODE_RUN);
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      mode_q         <= MODE_OFF;
      run_cnt_q      <= '0;
      standby_pend_q <= 1'b0;
      sleep_pend_q   <= 1'b0;
      run_power_q    <= 1'b0;
      irq_q          <= 1'b0;
      run_timeout_q  <= 1'b0;
    end
    else
    begin
      mode_q         <= mode_d;
      run_cnt_q      <= run_cnt_d;
      standby_pend_q <= standby_pend_d;
      sleep_pend_q   <= sleep_pend_d;
      run_power_q    <= run_power_d;
      irq_q          <= irq_d;
      run_timeout_q  <= timeout_d;
    end
  end

  // Switch outputs follow the EEPROM and latch words every cycle.
  logic sw_vfield_d;
  logic sw_reg_en_d;
  logic sw_bypass_d;
  logic sw_hivolt_d;
  logic sw_xtal_d;
  logic sw_rc_d;
  logic low_mode;

  always_comb
  begin
    low_mode    = (mode_d == MODE_SLEEP) || (mode_d == MODE_STANDBY);
    sw_vfield_d = !dev_word03[`DEV03_VFIELD_BIT];
    sw_bypass_d = dev_word04[`DEV04_BYPASS_BIT];
    sw_hivolt_d = dev_word04[`DEV04_HIVOLT_BIT];
    sw_xtal_d   = xtal_select;
    sw_rc_d     = !xtal_select;
    if (mode_d == MODE_OFF)
      sw_reg_en_d = 1'b0;
    else if (ee_word12[`EE12_EXTSUP_BIT])
      sw_reg_en_d = (mode_d == MODE_WATCH);
    else
      sw_reg_en_d = !(low_mode && regout_lowpower_off);
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      vfield_vbat_closed_q      <= 1'b1;
      regulated_output_en_q     <= 1'b0;
      regulated_output_bypass_q <= 1'b0;
      hivolt_q                  <= 1'b0;
      lf_xtal_en_q              <= 1'b0;
      lf_rc_en_q                <= 1'b1;
    end
    else
    begin
      vfield_vbat_closed_q      <= sw_vfield_d;
      regulated_output_en_q     <= sw_reg_en_d;
      regulated_output_bypass_q <= sw_bypass_d;
      hivolt_q                  <= sw_hivolt_d;
      lf_xtal_en_q              <= sw_xtal_d;
      lf_rc_en_q                <= sw_rc_d;
    end
  end

  sequence s_powered_off;
    (mode_q == MODE_OFF) && powered;
  endsequence

  sequence s_run_enter;
    (mode_q == MODE_WATCH) && run_req && !(standby_pend_q || timer_cfg_write || log_done)
      && !(sleep_pend_q || sleep_req) && !(wake_tick && timer_standby_en) && powered;
  endsequence

  AST_POWER_UP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_powered_off |=> mode_q == MODE_WATCH)
    else $error("did not leave off mode when powered");

  AST_RUN_ENTER: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_run_enter |=> (mode_q == MODE_RUN) && run_power_q)
    else $error("run mode not entered on request");

  AST_RUN_BOUND: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_q == MODE_RUN) |-> run_cnt_q < RW'(RUN_LIMIT))
    else $error("run mode exceeded its limit");

  AST_STANDBY_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_q == MODE_STANDBY) && powered && !rf_field && !ss_held
      |=> mode_q == MODE_STANDBY)
    else $error("stand-by left without external event");

  AST_STANDBY_REQ: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_q == MODE_WATCH) && timer_cfg_write && powered |=> mode_q == MODE_STANDBY)
    else $error("stand-by not entered after timer word write");

  AST_SLEEP_IRQ: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq_q |-> $past(mode_q) == MODE_SLEEP && $past(wake_tick))
    else $error("irq pulse outside a sleep period tick");

  AST_SLEEP_EXIT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_q == MODE_SLEEP) && powered && rf_field |=> mode_q == MODE_WATCH)
    else $error("sleep not left on field");

  AST_SWITCH: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##1 vfield_vbat_closed_q == !$past(dev_word03[`DEV03_VFIELD_BIT]))
    else $error("field switch does not follow word 03");

  AST_EXTSUP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ee_word12[`EE12_EXTSUP_BIT] && mode_d != MODE_WATCH |=> !regulated_output_en_q)
    else $error("regulated output on outside watchful mode");
endmodule : power_mode_manager

/* pwr_regs.svh */
// Bit positions, default values and timing constants of the power mode manager.
`ifndef PWR_REGS_SVH
`define PWR_REGS_SVH
`define DEV03_VFIELD_BIT      15
`define DEV04_BYPASS_BIT      2
`define DEV04_HIVOLT_BIT      3
`define EE12_EXTSUP_BIT       13
`define SS_HOLD_NS            1000
`define CLK_PERIOD_NS         40
`define RUN_LIMIT_DEFAULT     1000
`define WAKE_PERIOD_DEFAULT   32768
`endif

/* pwr_pkg.sv */
// Types shared by the power mode manager files.
package pwr_pkg;
  typedef enum logic [2:0]
  {
    MODE_OFF,
    MODE_WATCH,
    MODE_RUN,
    MODE_STANDBY,
    MODE_SLEEP
  } pwr_mode_t;
endpackage : pwr_pkg

/* ss_hold_filter.sv */
// Detects slave select held low for a minimum number of cycles.
`timescale 1ns/1ps
`include "pwr_regs.svh"
module ss_hold_filter #(
  parameter int HOLD_CYCLES = (`SS_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)
(
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic ss_n,
  output logic      held_q
);
  localparam int CW = $clog2(HOLD_CYCLES + 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          held_d;

  initial
  begin
    if (HOLD_CYCLES < 1)
      $error("HOLD_CYCLES must be at least one");
  end

  always_comb
  begin
    cnt_d  = cnt_q;
    held_d = 1'b0;
    if (ss_n)
      cnt_d = '0;
    else if (cnt_q < CW'(HOLD_CYCLES))
      cnt_d = cnt_q + CW'(1);
    if (!ss_n && cnt_q >= CW'(HOLD_CYCLES - 1))
      held_d = 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cnt_q  <= '0;
      held_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      held_q <= held_d;
    end
  end
endmodule : ss_hold_filter

/* wake_timer.sv */
// Programmable period timer that raises a one-cycle tick on expiry.
`timescale 1ns/1ps
module wake_timer #(
  parameter int W = 16
)
(
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  output logic              tick_q
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_d;

  initial
  begin
    if (W < 2)
      $error("W must be at least two");
  end

  always_comb
  begin
    cnt_d  = '0;
    tick_d = 1'b0;
    if (run)
    begin
      if (cnt_q + W'(1) >= period)
        tick_d = 1'b1;
      else
        cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end
endmodule : wake_timer

/* host_model.sv */
// Far-side host model: slave select hold, wake timer word writes and interrupt counting.
`timescale 1ns/1ps
module host_model #(
  parameter int HOLD = 25
)
(
  input  wire logic sys_clk,
  input  wire logic irq_q,
  input  wire logic ss_go,
  input  wire logic cfg_go,
  output logic      spi_ss_n,
  output logic      timer_cfg_write,
  output int        irq_count
);
  int hold_q;

  initial
  begin
    spi_ss_n = 1'b1;
    timer_cfg_write = 1'b0;
    irq_count = 0;
    hold_q = 0;
  end

  // Select is held two cycles past the filter length, so an edge-exact filter still fires.
  always @(posedge sys_clk)
  begin
    timer_cfg_write <= cfg_go;
    if (ss_go)
      hold_q <= HOLD + 2;
    else if (hold_q != 0)
      hold_q <= hold_q - 1;
    spi_ss_n <= !(ss_go || hold_q > 1);
    if (irq_q === 1'b1)
      irq_count <= irq_count + 1;
  end
endmodule : host_model

/* power_mode_manager_tb.sv */
// Self-checking testbench of the power mode manager.
`timescale 1ns/1ps
module power_mode_manager_tb;
  import pwr_pkg::*;
  logic        sys_clk, sys_rst, battery_present, timer_standby_en, xtal_select;
  logic        regout_lowpower_off, spi_ss_n, timer_cfg_write;
  logic [8:0]  ev;
  logic [15:0] wake_period, dev_word03, dev_word04, ee_word12;
  pwr_mode_t   mode_q;
  logic        run_power_q, irq_q, lf_xtal_en_q, lf_rc_en_q, vfield_vbat_closed_q;
  logic        regulated_output_en_q, regulated_output_bypass_q, hivolt_q, run_timeout_q;
  int          err_count, check_count, irq_count, n0;

  power_mode_manager #(.RUN_LIMIT(8), .WAKE_W(16)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .battery_present(battery_present),
    .rf_field(ev[6]), .spi_cmd(ev[0]), .rfid_cmd(ev[1]), .dma_req(ev[2]),
    .run_done(ev[3]), .timer_cfg_write(timer_cfg_write), .timer_standby_en(timer_standby_en),
    .log_done(ev[4]), .sleep_req(ev[5]), .spi_ss_n(spi_ss_n), .wake_period(wake_period),
    .xtal_select(xtal_select), .regout_lowpower_off(regout_lowpower_off),
    .dev_word03(dev_word03), .dev_word04(dev_word04), .ee_word12(ee_word12),
    .mode_q(mode_q), .run_power_q(run_power_q), .irq_q(irq_q), .lf_xtal_en_q(lf_xtal_en_q),
    .lf_rc_en_q(lf_rc_en_q), .vfield_vbat_closed_q(vfield_vbat_closed_q),
    .regulated_output_en_q(regulated_output_en_q),
    .regulated_output_bypass_q(regulated_output_bypass_q), .hivolt_q(hivolt_q),
    .run_timeout_q(run_timeout_q));

  host_model #(.HOLD(25)) host_u (
    .sys_clk(sys_clk), .irq_q(irq_q), .ss_go(ev[8]), .cfg_go(ev[7]),
    .spi_ss_n(spi_ss_n), .timer_cfg_write(timer_cfg_write), .irq_count(irq_count));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // One-cycle event on bit k; returns just after the edge that has taken it.
  task pulse(input int k);
    @(posedge sys_clk) ev[k] <= 1'b1;
    @(posedge sys_clk) ev[k] <= 1'b0;
    #1;
  endtask : pulse

  task wait_mode(input pwr_mode_t m, input int lim);
    for (int i = 0; i < lim && mode_q !== m; i++)
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask : wait_mode

  task wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial
  begin
    #(2000 * 40);
    err_count++;
    wrap_up();
  end

  initial
  begin
    {sys_rst, battery_present, timer_standby_en, xtal_select} = 4'h8;
    {regout_lowpower_off, ev} = 10'h000;
    {wake_period, dev_word03, dev_word04, ee_word12} = {16'h0004, 48'h0};
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    check(mode_q, MODE_OFF);
    check(vfield_vbat_closed_q, 1'b1);
    check(lf_rc_en_q, 1'b1);
    @(posedge sys_clk) battery_present <= 1'b1;
    wait_mode(MODE_WATCH, 4);
    check(mode_q, MODE_WATCH);
    $display("power-up done");
    for (int k = 0; k < 3; k++)
    begin
      pulse(k);
      check(mode_q, MODE_RUN);
      check(run_power_q, 1'b1);
      pulse(3);
      check(mode_q, MODE_WATCH);
    end
    pulse(0);
    for (n0 = 0; n0 < 12 && run_timeout_q !== 1'b1; n0++)
      @(posedge sys_clk) #1;
    check(run_timeout_q, 1'b1);
    check(n0[15:0], 16'h0008);
    wait_mode(MODE_WATCH, 3);
    check(mode_q, MODE_WATCH);
    $display("run done");
    @(posedge sys_clk) regout_lowpower_off <= 1'b1;
    pulse(7);
    wait_mode(MODE_STANDBY, 4);
    check(mode_q, MODE_STANDBY);
    check(regulated_output_en_q, 1'b0);
    pulse(0);
    repeat (20) @(posedge sys_clk);
    #1;
    check(mode_q, MODE_STANDBY);
    pulse(8);
    wait_mode(MODE_WATCH, 40);
    check(mode_q, MODE_WATCH);
    pulse(4);
    wait_mode(MODE_STANDBY, 3);
    check(mode_q, MODE_STANDBY);
    pulse(6);
    wait_mode(MODE_WATCH, 3);
    check(mode_q, MODE_WATCH);
    @(posedge sys_clk) timer_standby_en <= 1'b1;
    wait_mode(MODE_STANDBY, 12);
    check(mode_q, MODE_STANDBY);
    @(posedge sys_clk) timer_standby_en <= 1'b0;
    pulse(6);
    wait_mode(MODE_WATCH, 3);
    $display("stand-by done");
    @(posedge sys_clk) xtal_select <= 1'b1;
    pulse(5);
    wait_mode(MODE_SLEEP, 3);
    check(mode_q, MODE_SLEEP);
    @(posedge sys_clk) #1;
    check(lf_xtal_en_q, 1'b1);
    check(lf_rc_en_q, 1'b0);
    check(regulated_output_en_q, 1'b0);
    n0 = irq_count;
    repeat (20) @(posedge sys_clk);
    #1;
    check(irq_count - n0 >= 4 && irq_count - n0 <= 5, 1'b1);
    pulse(2);
    check(mode_q, MODE_RUN);
    wait_mode(MODE_WATCH, 20);
    pulse(5);
    wait_mode(MODE_SLEEP, 3);
    check(mode_q, MODE_SLEEP);
    pulse(6);
    check(mode_q, MODE_WATCH);
    $display("sleep done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      dev_word03 <= {i[0], 15'h0};
      dev_word04 <= {12'h0, i[1], i[0], 2'b00};
      ee_word12 <= {2'b00, i[1], 13'h0};
      @(posedge sys_clk) #1;
      @(posedge sys_clk) #1;
      check(vfield_vbat_closed_q, !i[0]);
      check(regulated_output_bypass_q, i[0]);
      check(hivolt_q, i[1]);
      check(regulated_output_en_q, 1'b1);
    end
    pulse(0);
    @(posedge sys_clk) #1;
    check(regulated_output_en_q, 1'b0);
    wait_mode(MODE_WATCH, 20);
    @(posedge sys_clk) battery_present <= 1'b0;
    wait_mode(MODE_OFF, 3);
    check(mode_q, MODE_OFF);
    $display("switches done");
    wrap_up();
  end
endmodule : power_mode_manager_tb
